// ---- src/rsr_consts.svh ----
// offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RSR_CONSTS_SVH
`define RSR_CONSTS_SVH

// register offsets on the plain register port
`define RSR_ADDR_CAUSE        8'h00
`define RSR_ADDR_SETTLE_SEL   8'h01
`define RSR_ADDR_SETTLE_STAT  8'h02
`define RSR_ADDR_PORT_LATCH   8'h03
`define RSR_ADDR_PORT_DIR     8'h04
`define RSR_ADDR_PSW          8'h05
`define RSR_ADDR_DROOP_CFG    8'h06

// bit positions in the reset cause register
`define RSR_BIT_CAUSE_WDT     4
`define RSR_BIT_CAUSE_OSC     1
`define RSR_BIT_CAUSE_DROOP   0

// reset values
`define RSR_RST_CAUSE         8'h00
`define RSR_RST_PSW           8'h02
`define RSR_RST_PORT_LATCH    8'h00
`define RSR_RST_PORT_DIR      8'hFF
`define RSR_RST_SETTLE_SEL    8'h05
`define RSR_RST_SETTLE_STAT   8'h00
`define RSR_RST_DROOP_CFG     8'h00
`define RSR_RDATA_IDLE        8'h00

// reset vector table
`define RSR_RESET_VEC_LO      16'h0000
`define RSR_RESET_VEC_HI      16'h0001

// settle select range; each step doubles the wait
`define RSR_SETTLE_SEL_MIN    3'h1
`define RSR_SETTLE_SEL_MAX    3'h5

// timing
`define RSR_STOP_RING_PERIODS 17
`define RSR_CLK_PERIOD_PS     5000
`define RSR_PIN_LOW_MIN_US    10
`define RSR_PIN_LOW_MIN_CYC   ((`RSR_PIN_LOW_MIN_US * 1000000 + `RSR_CLK_PERIOD_PS - 1) / `RSR_CLK_PERIOD_PS)

`endif

// ---- src/rsr_pkg.sv ----
// types shared by the reset sequencer files
package rsr_pkg;

  // gray path: reset, stop, run, standby, settle
  typedef enum logic [2:0] {
    RSR_ST_RESET   = 3'h0,
    RSR_ST_STOP    = 3'h1,
    RSR_ST_RUN     = 3'h3,
    RSR_ST_STANDBY = 3'h2,
    RSR_ST_SETTLE  = 3'h6,
    RSR_ST_PINHOLD = 3'h7
  } rsr_state_t;

endpackage

// ---- src/rsr_tick_timer.sv ----
// ring-oscillator period counter with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none

module rsr_tick_timer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // control
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_len,
  input  wire logic         i_tick,
  // status
  output logic              o_done,
  output logic [W-1:0]      o_elapsed
);

  logic         run_q;
  logic [W-1:0] cnt_q;
  logic [W-1:0] len_q;
  wire  [W-1:0] cnt_inc = cnt_q + {{(W-1){1'b0}}, 1'b1};
  wire          last    = run_q & i_tick & (cnt_inc == len_q);

  // length latched at start so a later register write cannot stretch a wait
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_q  <= 1'b0;
      cnt_q  <= '0;
      len_q  <= '0;
      o_done <= 1'b0;
    end else if (i_start) begin
      run_q  <= 1'b1;
      cnt_q  <= '0;
      len_q  <= i_len;
      o_done <= 1'b0;
    end else begin
      if (run_q && i_tick) cnt_q <= cnt_inc;
      if (last) run_q <= 1'b0;
      o_done <= last;
    end
  end

  assign o_elapsed = cnt_q;

endmodule // rsr_tick_timer

`default_nettype wire

// ---- src/rsr_top.sv ----
// reset merging, restart sequencing and deep-standby release
//
// The implementer's own choices: the plain strobed port and the register addresses.
`include "rsr_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module rsr_top
  import rsr_pkg::*;
#(
  parameter int          N_IRQ       = 8,
  parameter logic [15:0] SETTLE_BASE = 16'h0100
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // register port
  input  wire logic [7:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic [7:0]            o_rdata,
  // reset sources
  input  wire logic             i_reset_pin_n,
  input  wire logic             i_wdt_overflow,
  input  wire logic             i_osc_stop_detect,
  input  wire logic             i_poc_below,
  input  wire logic             i_droop_below,
  // ring oscillator period marker
  input  wire logic             i_ring_tick,
  // standby and interrupt state
  input  wire logic             i_stop_req,
  input  wire logic [N_IRQ-1:0] i_irq_request,
  input  wire logic [N_IRQ-1:0] i_interrupt_mask_flag,
  input  wire logic [N_IRQ-1:0] i_priority_level_flag,
  input  wire logic             i_global_interrupt_enable,
  input  wire logic             i_in_service_priority_flag,
  // core control
  output logic                  o_sys_rst,
  output logic                  o_cpu_clk_en,
  output logic                  o_pc_load,
  output logic [15:0]           o_vec_lo_addr,
  output logic [15:0]           o_vec_hi_addr,
  output logic                  o_irq_service,
  output logic                  o_next_instr,
  output logic                  o_in_standby,
  output logic                  o_hold_state,
  // oscillators and watchdog
  output logic                  o_main_osc_en,
  output logic                  o_ring_osc_en,
  output logic                  o_wdt_reset,
  // ports and indicator pin
  output logic [7:0]            o_port_out,
  output logic [7:0]            o_port_oe_n,
  output logic                  o_rst_ind_o,
  output logic                  o_rst_ind_oe_n,
  // register views
  output logic [7:0]            o_psw,
  output logic [7:0]            o_droop_cfg
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // settle wait in ring periods; select is clamped into its legal range
  function automatic logic [15:0] settle_len(input logic [7:0] sel, input logic [15:0] base);
    logic [2:0] s;
    s = sel[2:0];
    if (sel > {5'h00, `RSR_SETTLE_SEL_MAX}) s = `RSR_SETTLE_SEL_MAX;
    if (s < `RSR_SETTLE_SEL_MIN) s = `RSR_SETTLE_SEL_MIN;
    settle_len = base << (s - `RSR_SETTLE_SEL_MIN);
  endfunction

  // one status bit per settle step that has already elapsed
  function automatic logic [7:0] stage_bits(input logic [15:0] el, input logic [15:0] base);
    logic [7:0] b;
    b = 8'h00;
    for (int k = 0; k < 5; k++) begin
      if (el >= (base << k)) b[k] = 1'b1;
    end
    stage_bits = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state and registers

  rsr_state_t state_q;
  rsr_state_t state_d;
  logic       pend_q;     // settle wait belongs to a pin reset from standby
  logic       svc_q;      // wake interrupt is to be serviced
  logic [7:0] cause_q;
  logic [7:0] sel_q;
  logic [7:0] stat_q;
  logic [7:0] latch_q;
  logic [7:0] dir_q;
  logic [7:0] psw_q;
  logic [7:0] droop_q;

  wire [15:0] tmr_elapsed;
  wire        tmr_done;

  ////////////////////////////////////////////////////////////////////////////
  // source merging and wake decode

  wire pin_low  = ~i_reset_pin_n;
  wire src_int  = i_wdt_overflow | i_osc_stop_detect | i_poc_below | i_droop_below;
  wire src_any  = pin_low | src_int;
  wire src_nondroop = pin_low | i_wdt_overflow | i_osc_stop_detect | i_poc_below;

  wire [N_IRQ-1:0] unmasked = i_irq_request & ~i_interrupt_mask_flag;
  wire wake     = |unmasked;
  wire hi_pend  = |(unmasked & ~i_priority_level_flag);
  // high priority needs enable only; low also needs the in-service flag
  wire take     = i_global_interrupt_enable & (hi_pend | i_in_service_priority_flag);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RSR_ST_RESET: begin
        // held while any source stands; release aligned to a ring period
        if (!src_any && i_ring_tick) state_d = RSR_ST_STOP;
      end
      RSR_ST_STOP: begin
        if (src_any) state_d = RSR_ST_RESET;
        else if (tmr_done) state_d = RSR_ST_RUN;
      end
      RSR_ST_RUN: begin
        if (src_any) state_d = RSR_ST_RESET;
        else if (i_stop_req) state_d = RSR_ST_STANDBY;
      end
      RSR_ST_STANDBY: begin
        if (pin_low) state_d = RSR_ST_PINHOLD;
        else if (src_int) state_d = RSR_ST_RESET;
        else if (wake) state_d = RSR_ST_SETTLE;
      end
      RSR_ST_PINHOLD: begin
        if (src_int) state_d = RSR_ST_RESET;
        else if (!pin_low) state_d = RSR_ST_SETTLE;
      end
      RSR_ST_SETTLE: begin
        if (src_int) state_d = RSR_ST_RESET;
        else if (pin_low) state_d = pend_q ? RSR_ST_PINHOLD : RSR_ST_RESET;
        else if (tmr_done) state_d = pend_q ? RSR_ST_STOP : RSR_ST_RUN;
      end
      default: state_d = RSR_ST_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded events

  wire enter_stop   = (state_d == RSR_ST_STOP) & (state_q != RSR_ST_STOP);
  wire enter_settle = (state_d == RSR_ST_SETTLE) & (state_q != RSR_ST_SETTLE);
  wire pin_fire     = (state_q == RSR_ST_SETTLE) & pend_q & (state_d == RSR_ST_STOP);
  wire wake_done    = (state_q == RSR_ST_SETTLE) & ~pend_q & (state_d == RSR_ST_RUN);
  // same init for every source; pin reset from standby waits until settled
  wire init_now     = (state_d == RSR_ST_RESET) | pin_fire;
  // droop config survives a reset only the droop detector asked for
  wire droop_clr    = ((state_d == RSR_ST_RESET) & src_nondroop) | pin_fire;
  wire pend_d       = (state_d == RSR_ST_SETTLE) &
                      (pend_q | (state_q == RSR_ST_PINHOLD));
  // ports float through reset, the restart stop and a pin wake from standby
  wire hiz_d        = (state_d == RSR_ST_RESET) | (state_d == RSR_ST_STOP) |
                      (state_d == RSR_ST_PINHOLD) | pend_d;
  wire hold_d       = (state_d == RSR_ST_PINHOLD) | pend_d;
  wire tmr_start    = enter_stop | enter_settle;
  wire [15:0] tmr_len = enter_stop ? 16'(`RSR_STOP_RING_PERIODS) : settle_len(sel_q, SETTLE_BASE);

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  wire wr_sel   = i_wr & (i_addr == `RSR_ADDR_SETTLE_SEL);
  wire wr_latch = i_wr & (i_addr == `RSR_ADDR_PORT_LATCH);
  wire wr_dir   = i_wr & (i_addr == `RSR_ADDR_PORT_DIR);
  wire wr_psw   = i_wr & (i_addr == `RSR_ADDR_PSW);
  wire wr_droop = i_wr & (i_addr == `RSR_ADDR_DROOP_CFG);
  wire rd_cause = i_rd & (i_addr == `RSR_ADDR_CAUSE);

  // cause flags: hardware set wins over any clear in the same cycle
  wire [7:0] cause_set = ({7'h00, i_wdt_overflow} << `RSR_BIT_CAUSE_WDT) |
                         ({7'h00, i_osc_stop_detect} << `RSR_BIT_CAUSE_OSC) |
                         ({7'h00, i_droop_below} << `RSR_BIT_CAUSE_DROOP);
  wire       cause_clr = pin_low | i_poc_below | rd_cause;
  wire [7:0] cause_d   = (cause_clr ? `RSR_RST_CAUSE : cause_q) | cause_set;

  wire [7:0] sel_d   = init_now ? `RSR_RST_SETTLE_SEL : (wr_sel ? i_wdata : sel_q);
  wire [7:0] stat_d  = init_now ? `RSR_RST_SETTLE_STAT :
                       enter_settle ? `RSR_RST_SETTLE_STAT :
                       (state_q == RSR_ST_SETTLE) ? (stat_q | stage_bits(tmr_elapsed, SETTLE_BASE)) :
                       stat_q;
  wire [7:0] latch_d = init_now ? `RSR_RST_PORT_LATCH : (wr_latch ? i_wdata : latch_q);
  wire [7:0] dir_d   = init_now ? `RSR_RST_PORT_DIR : (wr_dir ? i_wdata : dir_q);
  wire [7:0] psw_d   = init_now ? `RSR_RST_PSW : (wr_psw ? i_wdata : psw_q);
  wire [7:0] droop_d = droop_clr ? `RSR_RST_DROOP_CFG : (wr_droop ? i_wdata : droop_q);

  // read mux; unmapped offsets answer zero
  wire [7:0] rd_mux =
    (i_addr == `RSR_ADDR_CAUSE)       ? cause_q :
    (i_addr == `RSR_ADDR_SETTLE_SEL)  ? sel_q :
    (i_addr == `RSR_ADDR_SETTLE_STAT) ? stat_q :
    (i_addr == `RSR_ADDR_PORT_LATCH)  ? latch_q :
    (i_addr == `RSR_ADDR_PORT_DIR)    ? dir_q :
    (i_addr == `RSR_ADDR_PSW)         ? psw_q :
    (i_addr == `RSR_ADDR_DROOP_CFG)   ? droop_q : `RSR_RDATA_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // ring period timer shared by the restart stop and the settle wait

  rsr_tick_timer #(.W(16)) u_timer (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_start   (tmr_start),
    .i_len     (tmr_len),
    .i_tick    (i_ring_tick),
    .o_done    (tmr_done),
    .o_elapsed (tmr_elapsed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= RSR_ST_RESET;
      pend_q  <= 1'b0;
      svc_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      pend_q  <= pend_d;
      if (enter_settle) svc_q <= take;
    end
  end

  // software-visible registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cause_q <= `RSR_RST_CAUSE;
      sel_q   <= `RSR_RST_SETTLE_SEL;
      stat_q  <= `RSR_RST_SETTLE_STAT;
      latch_q <= `RSR_RST_PORT_LATCH;
      dir_q   <= `RSR_RST_PORT_DIR;
      psw_q   <= `RSR_RST_PSW;
      droop_q <= `RSR_RST_DROOP_CFG;
    end else begin
      cause_q <= cause_d;
      sel_q   <= sel_d;
      stat_q  <= stat_d;
      latch_q <= latch_d;
      dir_q   <= dir_d;
      psw_q   <= psw_d;
      droop_q <= droop_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs, built from next values so they track the state

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata        <= `RSR_RDATA_IDLE;
      o_sys_rst      <= 1'b1;
      o_cpu_clk_en   <= 1'b0;
      o_pc_load      <= 1'b0;
      o_irq_service  <= 1'b0;
      o_next_instr   <= 1'b0;
      o_in_standby   <= 1'b0;
      o_hold_state   <= 1'b0;
      o_main_osc_en  <= 1'b1;
      o_ring_osc_en  <= 1'b1;
      o_wdt_reset    <= 1'b0;
      o_port_oe_n    <= 8'hFF;
      o_rst_ind_oe_n <= 1'b0;
    end else begin
      o_rdata        <= i_rd ? rd_mux : `RSR_RDATA_IDLE;
      o_sys_rst      <= (state_d == RSR_ST_RESET);
      o_cpu_clk_en   <= (state_d == RSR_ST_RUN);
      o_pc_load      <= (state_q == RSR_ST_STOP) & (state_d == RSR_ST_RUN);
      o_irq_service  <= wake_done & svc_q;
      o_next_instr   <= wake_done & ~svc_q;
      o_in_standby   <= (state_d == RSR_ST_STANDBY);
      o_hold_state   <= hold_d;
      // main oscillator sleeps in standby; both stop while the pin is low
      o_main_osc_en  <= ~pin_low & (state_d != RSR_ST_STANDBY) &
                        (state_d != RSR_ST_PINHOLD);
      o_ring_osc_en  <= ~pin_low;
      o_wdt_reset    <= i_wdt_overflow;
      o_port_oe_n    <= hiz_d ? 8'hFF : dir_d;
      o_rst_ind_oe_n <= ~hiz_d;
    end
  end

  // constant-valued flops: vectors and the indicator level
  always_ff @(posedge i_clk) begin
    o_vec_lo_addr <= `RSR_RESET_VEC_LO;
    o_vec_hi_addr <= `RSR_RESET_VEC_HI;
    o_rst_ind_o   <= 1'b0;
  end

  // port and register views
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_port_out  <= `RSR_RST_PORT_LATCH;
      o_psw       <= `RSR_RST_PSW;
      o_droop_cfg <= `RSR_RST_DROOP_CFG;
    end else begin
      o_port_out  <= latch_d;
      o_psw       <= psw_d;
      o_droop_cfg <= droop_d;
    end
  end

endmodule // rsr_top

`default_nettype wire

// ---- tb/rsr_monitor.sv ----
// port assertions for the reset sequencer, bound into rsr_top
`timescale 1ns/1ps
`default_nettype none

module rsr_monitor #(
  parameter int N_IRQ = 8
) (
  // clock and reset
  input wire logic             i_clk,
  input wire logic             i_rst,
  // sources and requests
  input wire logic             i_reset_pin_n,
  input wire logic             i_wdt_overflow,
  input wire logic             i_osc_stop_detect,
  input wire logic             i_poc_below,
  input wire logic             i_droop_below,
  input wire logic             i_ring_tick,
  input wire logic [N_IRQ-1:0] i_irq_request,
  input wire logic [N_IRQ-1:0] i_interrupt_mask_flag,
  // core side results
  input wire logic             o_sys_rst,
  input wire logic             o_cpu_clk_en,
  input wire logic             o_pc_load,
  input wire logic [15:0]      o_vec_lo_addr,
  input wire logic [15:0]      o_vec_hi_addr,
  input wire logic             o_in_standby,
  input wire logic             o_hold_state,
  input wire logic             o_main_osc_en,
  input wire logic             o_ring_osc_en,
  input wire logic             o_wdt_reset,
  input wire logic [7:0]       o_port_oe_n,
  input wire logic             o_rst_ind_o,
  input wire logic             o_rst_ind_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // merged internal sources and unmasked wake requests
  wire src  = i_wdt_overflow | i_osc_stop_detect | i_poc_below | i_droop_below;
  wire wake = |(i_irq_request & ~i_interrupt_mask_flag);

  // ring ticks since reset release; saturates so a stuck stop cannot wrap
  logic [4:0] tick_q;
  logic       from_rst_q;
  always_ff @(posedge i_clk) begin
    if (o_sys_rst)
      tick_q <= 5'h00;
    else if (i_ring_tick && tick_q != 5'h1F)
      tick_q <= tick_q + 5'h01;
  end
  // marks a restart that began in the reset state, not in the pin hold
  always_ff @(posedge i_clk) begin
    if (o_sys_rst)
      from_rst_q <= 1'b1;
    else if (o_pc_load)
      from_rst_q <= 1'b0;
  end

  a_src_to_reset: assert property (src && !o_in_standby && !o_hold_state |=> o_sys_rst)
    else $error("internal source did not raise system reset");
  a_reset_floats: assert property (o_sys_rst |-> o_port_oe_n == 8'hFF &&
    !o_rst_ind_oe_n && !o_rst_ind_o)
    else $error("ports not floating during reset");
  a_vec_fixed: assert property (o_pc_load |-> o_vec_lo_addr == 16'h0000 && o_vec_hi_addr == 16'h0001)
    else $error("reset vector address wrong");
  a_release_on_tick: assert property ($fell(o_sys_rst) |-> $past(i_ring_tick))
    else $error("reset released off a ring period");
  a_stop_seventeen: assert property (o_pc_load && from_rst_q |-> tick_q == 5'h11 && o_cpu_clk_en)
    else $error("cpu clock stop not 17 ring periods");
  a_pin_stops_osc: assert property (!i_reset_pin_n |=> !o_ring_osc_en && !o_main_osc_en)
    else $error("oscillator running with pin low");
  a_wdt_self_reset: assert property (i_wdt_overflow |=> o_wdt_reset)
    else $error("watchdog not reset by its own overflow");
  a_wake_at_once: assert property (o_in_standby && wake && i_reset_pin_n && !src |=> !o_in_standby)
    else $error("unmasked request did not end standby");
  a_masked_holds: assert property (o_in_standby && !wake && i_reset_pin_n && !src |=> o_in_standby)
    else $error("standby left without a wake source");
  a_settle_gated: assert property ($fell(o_in_standby) && i_reset_pin_n |-> !o_cpu_clk_en [*3])
    else $error("cpu clock on during settle wait");
  a_hold_floats: assert property (o_hold_state |-> o_port_oe_n == 8'hFF && !o_rst_ind_oe_n)
    else $error("ports not floating in pin hold");

  // main scenarios reached
  c_standby: cover property ($rose(o_in_standby));
  c_restart: cover property (o_pc_load && from_rst_q);
  c_pin_hold: cover property ($rose(o_hold_state));
endmodule // rsr_monitor

bind rsr_top rsr_monitor #(.N_IRQ(N_IRQ)) u_mon (.i_clk, .i_rst, .i_reset_pin_n,
  .i_wdt_overflow, .i_osc_stop_detect, .i_poc_below, .i_droop_below, .i_ring_tick,
  .i_irq_request, .i_interrupt_mask_flag, .o_sys_rst, .o_cpu_clk_en, .o_pc_load,
  .o_vec_lo_addr, .o_vec_hi_addr, .o_in_standby, .o_hold_state, .o_main_osc_en,
  .o_ring_osc_en, .o_wdt_reset, .o_port_oe_n, .o_rst_ind_o, .o_rst_ind_oe_n);

`default_nettype wire

// ---- tb/rsr_far_model.sv ----
// far side model: ring oscillator period marker and external reset pin
`timescale 1ns/1ps
`default_nettype none

module rsr_far_model #(
  parameter int TICK_DIV = 4,
  parameter int PIN_LOW  = 2000
) (
  input  wire logic i_clk,
  input  wire logic i_ring_osc_en,
  input  wire logic i_pin_go,
  output logic      o_ring_tick,
  output logic      o_reset_pin_n
);
  int div_q;
  int pin_q;
  initial begin
    o_ring_tick = 1'b0;
    o_reset_pin_n = 1'b1;
    div_q = 0;
    pin_q = 0;
  end
  // period marker only while the ring oscillator is allowed to run
  always @(posedge i_clk) begin
    if (!i_ring_osc_en) begin
      div_q <= 0;
      o_ring_tick <= 1'b0;
    end else begin
      div_q <= (div_q + 1) % TICK_DIV;
      o_ring_tick <= (div_q == TICK_DIV - 1);
    end
  end
  // pin held low for the whole minimum width once asked
  always @(posedge i_clk) begin
    if (i_pin_go)
      pin_q <= PIN_LOW;
    else if (pin_q != 0)
      pin_q <= pin_q - 1;
    o_reset_pin_n <= !(i_pin_go || pin_q > 1);
  end
endmodule // rsr_far_model

`default_nettype wire

// ---- tb/rsr_top_tb_top.sv ----
// self-checking testbench of the reset sequencer
`timescale 1ns/1ps
`default_nettype none

module rsr_top_tb_top;
  logic       clk, rst, wr, rd, pin_go, wdt, osc, power_on_clear_detector, droop, stop, gie, in_service_priority_flag;
  logic [7:0] addr, wdata, rdata, irq, mk, pr, oe_n, pout, program_status_word, dcfg;
  logic       sys_rst, clk_en, pc_load, svc, nxt, stby, hold, ring_en, tick, pin_n;
  logic       saw_svc, saw_nxt;
  int         bad_count, n_compared;

  rsr_top #(.N_IRQ(8), .SETTLE_BASE(16'h0004)) DUT (.i_clk(clk), .i_rst(rst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_reset_pin_n(pin_n), .i_wdt_overflow(wdt), .i_osc_stop_detect(osc),
    .i_poc_below(power_on_clear_detector), .i_droop_below(droop), .i_ring_tick(tick), .i_stop_req(stop),
    .i_irq_request(irq), .i_interrupt_mask_flag(mk), .i_priority_level_flag(pr),
    .i_global_interrupt_enable(gie), .i_in_service_priority_flag(in_service_priority_flag),
    .o_sys_rst(sys_rst), .o_cpu_clk_en(clk_en), .o_pc_load(pc_load),
    .o_vec_lo_addr(), .o_vec_hi_addr(), .o_irq_service(svc), .o_next_instr(nxt),
    .o_in_standby(stby), .o_hold_state(hold), .o_main_osc_en(), .o_ring_osc_en(ring_en),
    .o_wdt_reset(), .o_port_out(pout), .o_port_oe_n(oe_n), .o_rst_ind_o(),
    .o_rst_ind_oe_n(), .o_psw(program_status_word), .o_droop_cfg(dcfg));

  rsr_far_model #(.TICK_DIV(4), .PIN_LOW(2000)) u_far (.i_clk(clk), .i_ring_osc_en(ring_en),
    .i_pin_go(pin_go), .o_ring_tick(tick), .o_reset_pin_n(pin_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one-cycle strobes, changed just after the edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data only stand in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, exp, rdata);
  endtask

  // bounded wait for the cpu clock, noting the wake decision pulses
  task automatic wait_run;
    int k;
    saw_svc = 1'b0;
    saw_nxt = 1'b0;
    for (k = 0; k < 4000 && clk_en !== 1'b1; k++) begin
      @(posedge clk);
      #1;
      saw_svc |= svc;
      saw_nxt |= nxt;
    end
    chk("cpu_clk_en", 8'h01, {7'h00, clk_en});
  endtask

  // raise one internal source for len cycles, then wait for the restart
  task automatic hit(input int sel, input int len);
    @(posedge clk);
    case (sel)
      0: wdt <= 1'b1;
      1: osc <= 1'b1;
      2: droop <= 1'b1;
      default: power_on_clear_detector <= 1'b1;
    endcase
    repeat (len) @(posedge clk);
    {wdt, osc, droop, power_on_clear_detector} <= 4'h0;
    repeat (2) @(posedge clk);
    wait_run;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd_chk("psw", 8'h05, 8'h02);
    rd_chk("latch", 8'h03, 8'h00);
    rd_chk("dir", 8'h04, 8'hFF);
    rd_chk("settle_sel", 8'h01, 8'h05);
    rd_chk("settle_stat", 8'h02, 8'h00);
    wr_reg(8'h00, 8'h13);
    rd_chk("cause", 8'h00, 8'h00);
    rd_chk("unmapped", 8'h07, 8'h00);
    wr_reg(8'h01, 8'h03);
    rd_chk("settle_sel_rw", 8'h01, 8'h03);
    $display("test regs done");
  endtask

  task automatic t_wdt;
    wr_reg(8'h03, 8'h5A);
    wr_reg(8'h04, 8'h0F);
    wr_reg(8'h05, 8'h77);
    wr_reg(8'h06, 8'h33);
    // views settle in the step after the write edge
    #1;
    chk("port_out", 8'h5A, pout);
    chk("psw_view", 8'h77, program_status_word);
    chk("droop_view", 8'h33, dcfg);
    hit(0, 1);
    chk("port_out", 8'h00, pout);
    chk("psw_view", 8'h02, program_status_word);
    chk("droop_view", 8'h00, dcfg);
    rd_chk("settle_sel", 8'h01, 8'h05);
    rd_chk("cause", 8'h00, 8'h10);
    rd_chk("cause_cleared", 8'h00, 8'h00);
    rd_chk("psw", 8'h05, 8'h02);
    rd_chk("latch", 8'h03, 8'h00);
    rd_chk("dir", 8'h04, 8'hFF);
    rd_chk("droop_cfg", 8'h06, 8'h00);
    $display("test watchdog done");
  endtask

  // droop keeps its own setup; flags pile up; power-on clears them
  task automatic t_chain;
    wr_reg(8'h06, 8'h33);
    hit(2, 20);
    rd_chk("droop_cfg", 8'h06, 8'h33);
    hit(1, 1);
    rd_chk("cause", 8'h00, 8'h03);
    hit(0, 1);
    hit(3, 20);
    rd_chk("cause", 8'h00, 8'h00);
    $display("test chain done");
  endtask

  task automatic t_pin;
    hit(0, 1);
    @(posedge clk);
    pin_go <= 1'b1;
    @(posedge clk);
    pin_go <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk("ring_osc_en", 8'h00, {7'h00, ring_en});
    chk("sys_rst", 8'h01, {7'h00, sys_rst});
    wait_run;
    rd_chk("cause", 8'h00, 8'h00);
    $display("test pin done");
  endtask

  // exp: 0 next instruction, 1 service, 2 stays in standby
  task automatic t_wake(input logic m, input logic p, input logic e, input logic s,
                        input int exp);
    wr_reg(8'h03, 8'h5A);
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    repeat (3) @(posedge clk);
    mk <= {5'h1F, m, 2'h3};
    pr <= {5'h00, p, 2'h0};
    gie <= e;
    in_service_priority_flag <= s;
    irq <= 8'h04;
    if (exp == 2) begin
      repeat (20) @(posedge clk);
      pin_go <= 1'b1;
      #1 chk("standby", 8'h01, {7'h00, stby});
      @(posedge clk);
      pin_go <= 1'b0;
      repeat (10) @(posedge clk);
      #1 chk("hold", 8'h01, {7'h00, hold});
      chk("oe_n", 8'hFF, oe_n);
      wait_run;
      rd_chk("latch", 8'h03, 8'h00);
    end else begin
      wait_run;
      chk("service", exp[7:0], {7'h00, saw_svc});
      chk("next", 8'h01 - exp[7:0], {7'h00, saw_nxt});
      // a full wait at select 05 passes all five settle steps
      rd_chk("settle_stat", 8'h02, 8'h1F);
    end
    @(posedge clk);
    irq <= 8'h00;
    mk <= 8'hFF;
    $display("test wake %0d done", exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    {rst, wr, rd, pin_go, wdt, osc, power_on_clear_detector, droop, stop, gie, in_service_priority_flag} = 11'h400;
    {addr, wdata, irq} = 24'h000000;
    {mk, pr} = 16'hFFFF;
    bad_count = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wait_run;
    t_regs;
    t_wdt;
    t_chain;
    t_pin;
    t_wake(1'b0, 1'b0, 1'b0, 1'b0, 0);
    t_wake(1'b0, 1'b0, 1'b1, 1'b0, 1);
    t_wake(1'b0, 1'b1, 1'b0, 1'b1, 0);
    t_wake(1'b0, 1'b1, 1'b1, 1'b0, 0);
    t_wake(1'b0, 1'b1, 1'b1, 1'b1, 1);
    t_wake(1'b1, 1'b0, 1'b1, 1'b1, 2);
    end_of_test;
  end

  // hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    end_of_test;
  end
endmodule // rsr_top_tb_top

`default_nettype wire
